// [hw/rtcev_monitor.sv]
// Clock/calendar core with event detection, time stamp, alarm and frequency out.
// Assumes supply comparators and the crystal level arrive synchronous to clk_in,
// and that a plain register port stands in front of the serial bus.
// How it works
// - Accepted event sets flag, stores time stamp
// - Event optionally drives output, freezes clock
// - Event capture works on main and backup
// - Event input examined at selectable rate
// - Selectable filter rejects short input glitches
// - Calendar counters with leap years through 2099
// - Alarm matches any chosen field combination
// - Alarm flag polled, optionally on interrupt
// - Repeat keeps alarm firing periodically
// - Timebase from 32.768kHz crystal input
// - High event input means detected event
// - Enable bits gate event input, backup too
// - Selectable open-drain frequency output, idle high
// - Shared output; status tells alarm from event
// - Alarm pulls shared open-drain output low
// - Event holds shared output low until cleared
// - Bus ignored while on backup supply
// - Serial data open drain, up to 400kHz
// - Enter backup when both comparators say low
// - Leave backup when either comparator recovers
// - Filter times zero, 3.9, 15.6, 31.25 ms
// - Continuous or quarter, one, two hertz sampling
// - Clock stopped until clock register written
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module rtcev_monitor (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       crystal_input_in,
  input  wire logic       event_input_in,
  input  wire logic       vdd_below_bat_in,
  input  wire logic       vdd_below_trip_in,
  input  wire logic       vdd_above_bat_hys_in,
  input  wire logic       vdd_above_trip_hys_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  output logic            event_detect_output_out,
  output logic            event_detect_output_oe_out,
  output logic            fout_out,
  output logic            fout_oe_out,
  output logic            backup_mode_out
);

  rtcev_pkg::rtcev_state_type s;
  rtcev_pkg::rtcev_state_type n;

  logic           tick;
  logic           sec_pulse;
  logic           half_pulse;
  logic           rate_pulse;
  logic           frozen;
  logic           wr;
  logic           rd;
  logic           ev_gate;
  logic           sampling;
  logic           ev_hit;
  logic           clr_evt;
  logic           clr_alm;
  logic           fout_level;
  logic [10:0]    thr;
  logic [5:0][7:0] now_b;
  logic [3:0]     fsel;
  rtcev_pkg::rtcev_rate_type rate;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [4:0] days_in_month(input logic [3:0] m, input logic [6:0] y);
    // Years 00..99 map to 2000..2099, so every fourth year is leap
    unique case (m)
      4'h2:                      days_in_month = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB:    days_in_month = 5'h1E;
      default:                   days_in_month = 5'h1F;
    endcase
  endfunction

  function automatic logic [5:0][7:0] now_bytes(input rtcev_pkg::rtcev_state_type t);
    now_bytes = {{1'b0, t.year}, {4'h0, t.month}, {3'h0, t.date},
                 {3'h0, t.hour}, {2'h0, t.min}, {2'h0, t.sec}};
  endfunction

  function automatic logic alarm_hit(input rtcev_pkg::rtcev_state_type t);
    logic [5:0][7:0] cur;
    logic            any;
    logic            all;
    cur = {{5'h00, t.wday}, {4'h0, t.month}, {3'h0, t.date},
           {3'h0, t.hour}, {2'h0, t.min}, {2'h0, t.sec}};
    any = 1'b0;
    all = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (t.alm[i][rtcev_pkg::RTCEV_AL_EN]) begin
        any = 1'b1;
        if (t.alm[i][6:0] != cur[i][6:0]) begin
          all = 1'b0;
        end
      end
    end
    alarm_hit = any & all;
  endfunction

  function automatic logic [10:0] filt_ticks(input logic [1:0] sel);
    unique case (sel)
      2'h0: filt_ticks = 11'h000;
      2'h1: filt_ticks = rtcev_pkg::RTCEV_FILT_A_TICKS;
      2'h2: filt_ticks = rtcev_pkg::RTCEV_FILT_B_TICKS;
      2'h3: filt_ticks = rtcev_pkg::RTCEV_FILT_C_TICKS;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = s;
    // Time bytes as a plain vector; a function result cannot be indexed
    now_b = now_bytes(s);
    // Crystal rising edge is the only timebase; system clock just samples it
    tick = crystal_input_in & ~s.xtal_prev;
    n.xtal_prev = crystal_input_in;
    sec_pulse = 1'b0;
    half_pulse = 1'b0;
    if (tick) begin
      n.presc = s.presc + 15'h0001;
      half_pulse = (s.presc[13:0] == rtcev_pkg::RTCEV_HALF_TOP);
      if (s.presc == rtcev_pkg::RTCEV_PRESC_TOP) begin
        sec_pulse = 1'b1;
        n.qcnt = s.qcnt + 2'h1;
      end
    end
    frozen = s.event_flag & s.ctrl[rtcev_pkg::RTCEV_CT_FREEZE];
    // Bus is dead on backup supply
    wr = wr_in & ~s.backup;
    rd = rd_in & ~s.backup;

    // Calendar
    n.sec_upd = 1'b0;
    if (sec_pulse && s.running && !frozen) begin
      n.sec_upd = 1'b1;
      if (s.sec == 6'h3B) begin
        n.sec = 6'h00;
        if (s.min == 6'h3B) begin
          n.min = 6'h00;
          if (s.hour == 5'h17) begin
            n.hour = 5'h00;
            n.wday = (s.wday == 3'h6) ? 3'h0 : s.wday + 3'h1;
            if (s.date == days_in_month(s.month, s.year)) begin
              n.date = 5'h01;
              if (s.month == 4'hC) begin
                n.month = 4'h1;
                n.year = (s.year == 7'h63) ? 7'h00 : s.year + 7'h01;
              end else begin
                n.month = s.month + 4'h1;
              end
            end else begin
              n.date = s.date + 5'h01;
            end
          end else begin
            n.hour = s.hour + 5'h01;
          end
        end else begin
          n.min = s.min + 6'h01;
        end
      end else begin
        n.sec = s.sec + 6'h01;
      end
    end

    // Supply mode
    if (!s.backup && vdd_below_bat_in && vdd_below_trip_in) begin
      n.backup = 1'b1;
    end else if (s.backup && (vdd_above_bat_hys_in || vdd_above_trip_hys_in)) begin
      n.backup = 1'b0;
    end

    // Register writes
    clr_evt = 1'b0;
    clr_alm = 1'b0;
    if (wr) begin
      if (addr_in <= rtcev_pkg::RTCEV_ADDR_WDAY) begin
        n.running = 1'b1;
      end
      unique case (addr_in)
        8'h00: begin
          n.sec = wdata_in[5:0];
          n.presc = 15'h0000;
        end
        8'h01: n.min = wdata_in[5:0];
        8'h02: n.hour = wdata_in[4:0];
        8'h03: n.date = wdata_in[4:0];
        8'h04: n.month = wdata_in[3:0];
        8'h05: n.year = wdata_in[6:0];
        8'h06: n.wday = wdata_in[2:0];
        rtcev_pkg::RTCEV_ADDR_STATUS: begin
          clr_alm = wdata_in[rtcev_pkg::RTCEV_ST_ALARM];
          clr_evt = wdata_in[rtcev_pkg::RTCEV_ST_EVENT];
        end
        rtcev_pkg::RTCEV_ADDR_CTRL:  n.ctrl = wdata_in;
        rtcev_pkg::RTCEV_ADDR_EVCFG: n.evcfg = wdata_in;
        8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F:
          n.alm[3'(addr_in - rtcev_pkg::RTCEV_ADDR_ALARM)] = wdata_in;
        default: ;
      endcase
    end
    if (clr_alm) begin
      n.alarm_flag = 1'b0;
    end
    if (clr_evt) begin
      n.event_flag = 1'b0;
    end

    // Alarm, checked the cycle after each second step; set beats clear
    if (s.sec_upd && alarm_hit(s)) begin
      n.alarm_flag = 1'b1;
      if (!s.ctrl[rtcev_pkg::RTCEV_CT_REPEAT]) begin
        for (int i = 0; i < 6; i++) begin
          n.alm[i][rtcev_pkg::RTCEV_AL_EN] = 1'b0;
        end
      end
    end

    // Event input: gated, sampled, filtered
    ev_gate = event_input_in & s.ctrl[rtcev_pkg::RTCEV_CT_EV_EN]
            & (~s.backup | s.ctrl[rtcev_pkg::RTCEV_CT_EV_BKEN]);
    rate = rtcev_pkg::rtcev_rate_type'(s.evcfg[rtcev_pkg::RTCEV_EC_RATE_LO +: 2]);
    thr = filt_ticks(s.ctrl[rtcev_pkg::RTCEV_CT_FILT_LO +: 2]);
    unique case (rate)
      rtcev_pkg::RTCEV_RATE_CONT:    rate_pulse = 1'b0;
      rtcev_pkg::RTCEV_RATE_QUARTER: rate_pulse = sec_pulse & (s.qcnt == 2'h3);
      rtcev_pkg::RTCEV_RATE_ONE:     rate_pulse = sec_pulse;
      rtcev_pkg::RTCEV_RATE_TWO:     rate_pulse = half_pulse;
    endcase
    // Sampling window spans the filter time so a steady high can qualify
    sampling = (rate == rtcev_pkg::RTCEV_RATE_CONT) | s.win;
    if (rate_pulse) begin
      n.win = 1'b1;
      n.win_cnt = 11'h000;
    end else if (tick && s.win) begin
      if (s.win_cnt > thr) begin
        n.win = 1'b0;
      end else begin
        n.win_cnt = s.win_cnt + 11'h001;
      end
    end
    if (!sampling || !ev_gate) begin
      n.filt_cnt = 11'h000;
    end else if (tick && s.filt_cnt < thr) begin
      n.filt_cnt = s.filt_cnt + 11'h001;
    end
    ev_hit = sampling & ev_gate & (s.filt_cnt >= thr);
    // Works in either supply mode; only the gate looks at backup
    if (ev_hit && (!s.event_flag || clr_evt)) begin
      n.event_flag = 1'b1;
      n.stamp = now_bytes(s);
    end

    // Read data stands one cycle only
    n.rdata = 8'h00;
    if (rd) begin
      unique case (addr_in)
        8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05:
          n.rdata = now_b[3'(addr_in)];
        8'h06: n.rdata = {5'h00, s.wday};
        rtcev_pkg::RTCEV_ADDR_STATUS:
          n.rdata = {4'h0, ~s.running, s.backup, s.event_flag, s.alarm_flag};
        rtcev_pkg::RTCEV_ADDR_CTRL:  n.rdata = s.ctrl;
        rtcev_pkg::RTCEV_ADDR_EVCFG: n.rdata = s.evcfg;
        8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F:
          n.rdata = s.alm[3'(addr_in - rtcev_pkg::RTCEV_ADDR_ALARM)];
        8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15:
          n.rdata = s.stamp[3'(addr_in - rtcev_pkg::RTCEV_ADDR_STAMP)];
        default: n.rdata = 8'h00;
      endcase
    end

    // Shared open-drain output; follows the flags with no extra lag
    n.irq_oe = (n.alarm_flag & n.ctrl[rtcev_pkg::RTCEV_CT_IRQ_ALM])
             | (n.event_flag & n.ctrl[rtcev_pkg::RTCEV_CT_EV_OUT]);

    // Frequency output: crystal itself or a prescaler tap
    fsel = s.evcfg[rtcev_pkg::RTCEV_EC_FSEL_LO +: 4];
    fout_level = (fsel == 4'h0) ? crystal_input_in : s.presc[4'(fsel - 4'h1)];
    n.fout_oe = s.evcfg[rtcev_pkg::RTCEV_EC_FOUT_EN] & ~fout_level;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s <= rtcev_pkg::RTCEV_STATE_RESET;
    end else begin
      s <= n;
    end
  end

  // Open-drain serial data sits outside; this port is its stand-in
  assign rdata_out = s.rdata;
  // Open-drain pins only ever pull low; the enable carries the level
  assign event_detect_output_out = 1'b0;
  assign event_detect_output_oe_out = s.irq_oe;
  assign fout_out = 1'b0;
  assign fout_oe_out = s.fout_oe;
  assign backup_mode_out = s.backup;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_ev_rise;
    !s.event_flag ##1 s.event_flag;
  endsequence

  property p_stamp;
    s_ev_rise |-> s.stamp[0] == {2'h0, $past(s.sec)};
  endproperty
  a_stamp: assert property (p_stamp) else $error("stamp not captured");

  property p_freeze;
    (s.event_flag && s.ctrl[rtcev_pkg::RTCEV_CT_FREEZE] && !wr) |=> $stable(s.sec);
  endproperty
  a_freeze: assert property (p_freeze) else $error("clock moved while frozen");

  property p_gate;
    s_ev_rise |-> $past(ev_gate);
  endproperty
  a_gate: assert property (p_gate) else $error("event without gate");

  property p_sticky;
    (s.event_flag && !clr_evt) |=> s.event_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("event flag dropped");

  property p_evout;
    (s.event_flag && s.ctrl[rtcev_pkg::RTCEV_CT_EV_OUT]) |-> event_detect_output_oe_out;
  endproperty
  a_evout: assert property (p_evout) else $error("event output not low");

  property p_backup_bus;
    (s.backup && rd_in) |=> rdata_out == 8'h00;
  endproperty
  a_backup_bus: assert property (p_backup_bus) else $error("bus live in backup");

  property p_sec_wrap;
    (sec_pulse && s.running && !frozen && s.sec == 6'h3B && !wr) |=> s.sec == 6'h00;
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds wrap wrong");

  property p_fout_idle;
    !s.evcfg[rtcev_pkg::RTCEV_EC_FOUT_EN] |=> !fout_oe_out;
  endproperty
  a_fout_idle: assert property (p_fout_idle) else $error("fout driven when off");

  property p_enter_backup;
    $rose(s.backup) |-> $past(vdd_below_bat_in) && $past(vdd_below_trip_in);
  endproperty
  a_enter_backup: assert property (p_enter_backup) else $error("bad backup entry");

  property p_stopped;
    (!s.running && !wr) |=> $stable(s.sec) && $stable(s.min);
  endproperty
  a_stopped: assert property (p_stopped) else $error("clock ran unset");

  property p_filter;
    s_ev_rise |-> $past(s.filt_cnt) >= $past(thr);
  endproperty
  a_filter: assert property (p_filter) else $error("event passed filter early");

endmodule

// [common/rtcev_pkg.sv]
// Constants, register map and state record of the event-monitoring clock core.
// Assumes one 20 MHz system clock; the crystal arrives as a synchronous level.
package rtcev_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned RTCEV_CLK_HZ      = 20000000;
  localparam int unsigned RTCEV_XTAL_HZ     = 32768;
  localparam int unsigned RTCEV_FILT_A_US   = 3900;
  localparam int unsigned RTCEV_FILT_B_US   = 15625;
  localparam int unsigned RTCEV_FILT_C_US   = 31250;
  // Least times, rounded up to whole crystal ticks
  localparam logic [10:0] RTCEV_FILT_A_TICKS =
    11'((RTCEV_FILT_A_US * RTCEV_XTAL_HZ + 999999) / 1000000);
  localparam logic [10:0] RTCEV_FILT_B_TICKS =
    11'((RTCEV_FILT_B_US * RTCEV_XTAL_HZ + 999999) / 1000000);
  localparam logic [10:0] RTCEV_FILT_C_TICKS =
    11'((RTCEV_FILT_C_US * RTCEV_XTAL_HZ + 999999) / 1000000);
  localparam logic [14:0] RTCEV_PRESC_TOP    = 15'h7FFF;
  localparam logic [13:0] RTCEV_HALF_TOP     = 14'h3FFF;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] RTCEV_ADDR_SEC    = 8'h00;
  localparam logic [7:0] RTCEV_ADDR_WDAY   = 8'h06;
  localparam logic [7:0] RTCEV_ADDR_STATUS = 8'h07;
  localparam logic [7:0] RTCEV_ADDR_CTRL   = 8'h08;
  localparam logic [7:0] RTCEV_ADDR_EVCFG  = 8'h09;
  localparam logic [7:0] RTCEV_ADDR_ALARM  = 8'h0A;
  localparam logic [7:0] RTCEV_ADDR_STAMP  = 8'h10;

  // Status bits
  localparam int RTCEV_ST_ALARM   = 0;
  localparam int RTCEV_ST_EVENT   = 1;
  localparam int RTCEV_ST_BACKUP  = 2;
  localparam int RTCEV_ST_STOPPED = 3;
  // Control bits
  localparam int RTCEV_CT_EV_EN   = 0;
  localparam int RTCEV_CT_EV_BKEN = 1;
  localparam int RTCEV_CT_IRQ_ALM = 2;
  localparam int RTCEV_CT_FREEZE  = 3;
  localparam int RTCEV_CT_EV_OUT  = 4;
  localparam int RTCEV_CT_REPEAT  = 5;
  localparam int RTCEV_CT_FILT_LO = 6;
  // Event/frequency configuration bits
  localparam int RTCEV_EC_RATE_LO = 0;
  localparam int RTCEV_EC_FOUT_EN = 3;
  localparam int RTCEV_EC_FSEL_LO = 4;
  // Alarm field enable
  localparam int RTCEV_AL_EN      = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [4:0] RTCEV_DATE_RESET  = 5'h01;
  localparam logic [3:0] RTCEV_MONTH_RESET = 4'h1;

  typedef enum logic [1:0] {
    RTCEV_RATE_CONT    = 2'h0,
    RTCEV_RATE_QUARTER = 2'h1,
    RTCEV_RATE_ONE     = 2'h2,
    RTCEV_RATE_TWO     = 2'h3
  } rtcev_rate_type;

  typedef struct packed {
    logic            xtal_prev;
    logic [14:0]     presc;
    logic [1:0]      qcnt;
    logic [5:0]      sec;
    logic [5:0]      min;
    logic [4:0]      hour;
    logic [4:0]      date;
    logic [3:0]      month;
    logic [6:0]      year;
    logic [2:0]      wday;
    logic            sec_upd;
    logic            running;
    logic            backup;
    logic            alarm_flag;
    logic            event_flag;
    logic [7:0]      ctrl;
    logic [7:0]      evcfg;
    logic [5:0][7:0] alm;
    logic [5:0][7:0] stamp;
    logic            win;
    logic [10:0]     win_cnt;
    logic [10:0]     filt_cnt;
    logic [7:0]      rdata;
    logic            irq_oe;
    logic            fout_oe;
  } rtcev_state_type;

  localparam rtcev_state_type RTCEV_STATE_RESET = '{
    date:    RTCEV_DATE_RESET,
    month:   RTCEV_MONTH_RESET,
    default: '0
  };

endpackage

// [dv/rtcev_host.sv]
// Host model: bus master on the plain register port of the clock core.
// Assumes read data stand in the cycle after the read strobe and only there.
`timescale 1ns/1ps

module rtcev_host (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  initial begin
    addr_out  = 8'h00;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  ////////////////////////////////////////
  // Writing a one to a status flag clears it
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    // Released data never keeps its last value
    wdata_out <= ~d;
  endtask

  // Status read tells alarm from event
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    #1 d = rdata_in;
  endtask
endmodule

// [dv/rtcev_monitor_tb.sv]
// Self-checking bench of the event-monitoring clock core.
// Assumes a fast crystal level: one tick every two system clocks.
`timescale 1ns/1ps

module rtcev_monitor_tb;
  logic       clk_in;
  logic       resetn_in;
  logic       xtal;
  logic       ev;
  logic [3:0] vdd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       ev_oe;
  logic       fout_oe;
  logic       bkp;
  int         failures = 0;
  int         n_tests = 0;
  int         cyc = 0;

  rtcev_monitor i_rtcev_monitor (
    .clk_in                     (clk_in),
    .resetn_in                  (resetn_in),
    .crystal_input_in           (xtal),
    .event_input_in             (ev),
    .vdd_below_bat_in           (vdd[0]),
    .vdd_below_trip_in          (vdd[1]),
    .vdd_above_bat_hys_in       (vdd[2]),
    .vdd_above_trip_hys_in      (vdd[3]),
    .addr_in                    (addr),
    .wdata_in                   (wdata),
    .wr_in                      (wr),
    .rd_in                      (rd),
    .rdata_out                  (rdata),
    .event_detect_output_out    (),
    .event_detect_output_oe_out (ev_oe),
    .fout_out                   (),
    .fout_oe_out                (fout_oe),
    .backup_mode_out            (bkp)
  );

  rtcev_host i_rtcev_host (
    .clk_in    (clk_in),
    .rdata_in  (rdata),
    .addr_out  (addr),
    .wdata_out (wdata),
    .wr_out    (wr),
    .rd_out    (rd)
  );

  ////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    xtal <= ~xtal;
  end

  // Whole run is about 70k cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures++;
      conclude();
    end
  end

  ////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_rtcev_host.rd_reg(a, d);
    cmp(d, exp);
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    cmp({7'h00, got}, {7'h00, exp});
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // One second of the reference calendar, years 2000 to 2099
  function automatic void step(ref int v[7]);
    int dim;
    dim = (v[4] == 2) ? ((v[5] % 4 == 0) ? 29 : 28) : ((v[4] inside {4, 6, 9, 11}) ? 30 : 31);
    v[0] = (v[0] + 1) % 60;
    if (v[0] == 0) v[1] = (v[1] + 1) % 60;
    if (v[0] + v[1] == 0) v[2] = (v[2] + 1) % 24;
    if (v[0] + v[1] + v[2] == 0) begin
      v[6] = (v[6] + 1) % 7;
      v[3] = v[3] % dim + 1;
      if (v[3] == 1) v[4] = v[4] % 12 + 1;
      if (v[3] + v[4] == 2) v[5] = (v[5] + 1) % 100;
    end
  endfunction

  ////////////////////////////////////////
  initial begin
    int   v[7];
    int   q[$];
    int   k;
    int   n;
    logic p;
    int   ft[3] = '{128, 512, 1024};
    logic [7:0] fx[4] = '{8'h08, 8'h18, 8'h28, 8'h00};
    int   fe[4] = '{64, 32, 16, 0};
    resetn_in = 1'b0;
    xtal = 1'b0;
    ev = 1'b0;
    vdd = 4'h0;
    k = $urandom(73904);
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    chk_reg(8'h07, 8'h08);
    chk_reg(8'h03, 8'h01);
    chk_reg(8'h04, 8'h01);
    chk_pin(ev_oe | fout_oe | bkp, 1'b0);
    i_rtcev_host.wr_reg(8'h08, 8'h00);
    ev <= 1'b1;
    cyc_wait(4);
    chk_reg(8'h07, 8'h08);
    ev <= 1'b0;
    $display("done: reset and gated input");

    // Random time; seconds low enough that no carry lands mid-test
    v = '{$urandom_range(50), $urandom_range(59), $urandom_range(23),
          $urandom_range(28, 1), $urandom_range(12, 1), $urandom_range(99), $urandom_range(6)};
    for (k = 6; k >= 0; k--) i_rtcev_host.wr_reg(8'(k), 8'(v[k]));
    for (k = 0; k < 6; k++) q.push_back(v[k]);
    chk_reg(8'h07, 8'h00);
    i_rtcev_host.wr_reg(8'h08, 8'h19);
    ev <= 1'b1;
    cyc_wait(3);
    chk_pin(ev_oe, 1'b1);
    ev <= 1'b0;
    cyc_wait(4);
    chk_reg(8'h07, 8'h02);
    for (k = 0; k < 6; k++) chk_reg(8'h10 + 8'(k), 8'(q.pop_front()));
    chk_pin(ev_oe, 1'b1);
    i_rtcev_host.wr_reg(8'h07, 8'h02);
    cyc_wait(2);
    chk_pin(ev_oe, 1'b0);
    chk_reg(8'h07, 8'h00);
    $display("done: event and stamp");

    i_rtcev_host.wr_reg(8'h08, 8'h51);
    ev <= 1'b1;
    cyc_wait(2 * $urandom_range(120, 10));
    ev <= 1'b0;
    cyc_wait(300);
    chk_reg(8'h07, 8'h00);
    foreach (ft[i]) begin
      i_rtcev_host.wr_reg(8'h08, 8'h11 | (8'(i + 1) << 6));
      ev <= 1'b1;
      cyc_wait(2 * ft[i] - 24);
      chk_pin(ev_oe, 1'b0);
      cyc_wait(40);
      chk_pin(ev_oe, 1'b1);
      ev <= 1'b0;
      i_rtcev_host.wr_reg(8'h07, 8'h02);
    end
    $display("done: filter");

    i_rtcev_host.wr_reg(8'h08, 8'h13);
    vdd <= 4'h1;
    cyc_wait(3);
    chk_pin(bkp, 1'b0);
    vdd <= 4'h3;
    cyc_wait(2);
    chk_pin(bkp, 1'b1);
    chk_reg(8'h07, 8'h00);
    ev <= 1'b1;
    cyc_wait(3);
    chk_pin(ev_oe, 1'b1);
    ev <= 1'b0;
    i_rtcev_host.wr_reg(8'h07, 8'h02);
    vdd <= 4'h8;
    cyc_wait(2);
    chk_pin(bkp, 1'b0);
    vdd <= 4'h0;
    chk_reg(8'h07, 8'h02);
    i_rtcev_host.wr_reg(8'h07, 8'h02);
    $display("done: backup");

    foreach (fx[i]) begin
      i_rtcev_host.wr_reg(8'h09, fx[i]);
      cyc_wait(4);
      n = 0;
      repeat (64) begin
        p = fout_oe;
        cyc_wait(1);
        n += int'(fout_oe !== p);
      end
      chk_pin(n >= fe[i] - 2 && n <= fe[i] + 2, 1'b1);
    end
    chk_pin(fout_oe, 1'b0);
    $display("done: frequency output");

    // Leap day, weekday wrap and a date alarm in one second step;
    // held-high input only looked at on the half-second samples
    i_rtcev_host.wr_reg(8'h08, 8'h05);
    i_rtcev_host.wr_reg(8'h09, 8'h03);
    i_rtcev_host.wr_reg(8'h0D, 8'h9D);
    v = '{59, 59, 23, 28, 2, 24, 6};
    for (k = 6; k >= 0; k--) i_rtcev_host.wr_reg(8'(k), 8'(v[k]));
    for (k = 0; k < 6; k++) q.push_back(v[k]);
    ev <= 1'b1;
    cyc_wait(1);
    chk_pin(ev_oe, 1'b0);
    cyc_wait(200);
    chk_reg(8'h07, 8'h00);
    step(v);
    // Second steps 65536 cycles after the seconds write; flag one edge later
    cyc_wait(65336);
    ev <= 1'b0;
    chk_pin(ev_oe, 1'b1);
    chk_reg(8'h07, 8'h03);
    for (k = 0; k < 7; k++) chk_reg(8'(k), 8'(v[k]));
    for (k = 0; k < 6; k++) chk_reg(8'h10 + 8'(k), 8'(q.pop_front()));
    chk_reg(8'h0D, 8'h1D);
    i_rtcev_host.wr_reg(8'h07, 8'h03);
    cyc_wait(2);
    chk_pin(ev_oe, 1'b0);
    $display("done: calendar and alarm");
    conclude();
  end
endmodule
